// ===== hdl/added_irq_defs.vh
// Constants for the added interrupt status bank
//
// Summary of operation
// [R1] Tx early flag latches when enabled, W1C
// [R2] Rx early flag latches when enabled, W1C
// [R3] Transceiver flag is OR of bits 6..0
// [R4] Pause flag sets on pause frame if enabled
// [R5] Bus error kind: 000 par, 001 mabt, 010 tabt
// [R6] Kind valid only with fatal error; no irq
// [R7] Latched flags hold until written one
// [R8] Bits 14..0 mirror main status register
// [R9] Tx deferred flag latches, W1C, resets zero
`ifndef ADDED_IRQ_DEFS_VH
`define ADDED_IRQ_DEFS_VH
`define OFS_STATUS       12'h080
`define OFS_ENABLE       12'h084
`define OFS_MAIN_STATUS  12'h028
`define OFS_TRX_IRQ      12'h0A0
`define BIT_TX_EARLY     31
`define BIT_RX_EARLY     30
`define BIT_TRX          29
`define BIT_TX_DEFER     28
`define BIT_PAUSE        26
`define BIT_ANIE         16
`define BEK_HI           25
`define BEK_LO           23
`define BEK_PARITY       3'h0
`define BEK_MABORT       3'h1
`define BEK_TABORT       3'h2
`define MIRROR_HI        14
`define FATAL_BIT        13
`define EN_WMASK         32'hF401FFFF
`endif

// ===== hdl/added_interrupt_status_bank.v
// Added interrupt status and enable registers on APB
`timescale 1ns/1ps
`include "added_irq_defs.vh"
module added_interrupt_status_bank (
  // Clock and reset
  input  wire        core_clk,
  input  wire        reset,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // Events
  input  wire        tx_packet_moved,
  input  wire        rx_first_desc_filled,
  input  wire        tx_deferred,
  input  wire        pause_frame_rx,
  input  wire        pause_enable,
  input  wire [6:0]  transceiver_irq_register,
  input  wire [14:0] main_status_register,
  input  wire        bus_error,
  input  wire [2:0]  bus_error_cause,
  // Main status clear request, one-cycle pulse of W1C bits 14..0
  output reg  [14:0] main_status_clear,
  // Interrupt
  output reg         irq
);
  reg  [31:0] enable_r;
  reg         tx_early_irq_flag_r;
  reg         rx_early_irq_flag_r;
  reg         tx_deferred_irq_flag_r;
  reg         pause_rx_irq_flag_r;
  reg  [2:0]  bus_error_kind_r;
  reg         trx_irq_flag_r;
  wire        wr_acc;
  wire        rd_acc;
  wire        wr_stat;
  wire        wr_en;
  wire [31:0] status_word;
  wire [31:0] pending;
  reg  [31:0] rdata_nxt;
  reg         err_nxt;

  // Clear only on the completing access edge
  assign wr_acc  = psel & penable & pready & pwrite;
  assign rd_acc  = psel & ~penable & ~pwrite;
  assign wr_stat = wr_acc & (paddr == `OFS_STATUS);
  assign wr_en   = wr_acc & (paddr == `OFS_ENABLE);

  function w1c_next;
    input cur;
    input set;
    input clr;
    begin
      // Set wins over a simultaneous clear
      w1c_next = set | (cur & ~clr);
    end
  endfunction

  assign status_word = {tx_early_irq_flag_r, rx_early_irq_flag_r,
                        trx_irq_flag_r, tx_deferred_irq_flag_r, 1'b0,
                        pause_rx_irq_flag_r, bus_error_kind_r,
                        8'h00, main_status_register}; // R8
  // Error kind bits are not part of the pending set
  assign pending = status_word & enable_r &
                   {1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 26'h0000000}; // R6

  always @(posedge core_clk) begin
    if (reset) begin
      enable_r               <= 32'h00000000;
      tx_early_irq_flag_r    <= 1'b0;
      rx_early_irq_flag_r    <= 1'b0;
      tx_deferred_irq_flag_r <= 1'b0;
      pause_rx_irq_flag_r    <= 1'b0;
      trx_irq_flag_r         <= 1'b0;
      bus_error_kind_r       <= `BEK_PARITY;
      main_status_clear      <= 15'h0000;
      irq                    <= 1'b0;
    end else begin
      if (wr_en)
        enable_r <= pwdata & `EN_WMASK;
      tx_early_irq_flag_r <= w1c_next(tx_early_irq_flag_r,
        tx_packet_moved & enable_r[`BIT_TX_EARLY],
        wr_stat & pwdata[`BIT_TX_EARLY]); // R1 R7
      rx_early_irq_flag_r <= w1c_next(rx_early_irq_flag_r,
        rx_first_desc_filled & enable_r[`BIT_RX_EARLY],
        wr_stat & pwdata[`BIT_RX_EARLY]); // R2 R7
      tx_deferred_irq_flag_r <= w1c_next(tx_deferred_irq_flag_r,
        tx_deferred, wr_stat & pwdata[`BIT_TX_DEFER]); // R9
      pause_rx_irq_flag_r <= w1c_next(pause_rx_irq_flag_r,
        pause_frame_rx & pause_enable,
        wr_stat & pwdata[`BIT_PAUSE]); // R4
      trx_irq_flag_r <= |transceiver_irq_register; // R3
      // Cause is captured only when an error occurs; codes 011, 1xx reserved
      if (bus_error)
        bus_error_kind_r <= bus_error_cause; // R5
      main_status_clear <= wr_stat ? pwdata[`MIRROR_HI:0] : 15'h0000; // R8
      irq <= |pending;
    end
  end

  always @* begin
    rdata_nxt = 32'h00000000;
    err_nxt   = 1'b0;
    case (paddr)
      `OFS_STATUS: rdata_nxt = status_word;
      `OFS_ENABLE: rdata_nxt = enable_r;
      default:     err_nxt   = 1'b1;
    endcase
  end

  // No wait state: pready and data registered during setup
  always @(posedge core_clk) begin
    if (reset) begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & err_nxt;
      if (rd_acc)
        prdata <= rdata_nxt;
    end
  end
endmodule

// ===== dv/irq_bank_props.sv
// Port checks for the status bank
`timescale 1ns/1ps
module irq_props(input wire core_clk, reset, psel, penable, pwrite,
  input wire pready, pslverr, input wire [11:0] paddr,
  input wire [31:0] pwdata, prdata,
  input wire [6:0] transceiver_irq_register,
  input wire [14:0] main_status_register, main_status_clear);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  wire su = psel && !penable;
  wire rs = su && !pwrite && paddr == 12'h080;
  wire ws = psel && penable && pready && pwrite && paddr == 12'h080;
  a_ready_next: assert property (su |=> pready)
    else $error("ready late");
  a_ready_once: assert property (pready |=> !pready)
    else $error("ready long");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("stray error");
  a_err_unmapped: assert property (su && paddr == 12'h0FC |=> pslverr)
    else $error("not refused");
  a_clear_pulse: assert property (
    ws |=> main_status_clear == $past(pwdata[14:0])) else $error("bad clear");
  a_clear_idle: assert property (
    !(psel && pwrite) |=> main_status_clear == 15'h0) else $error("stray clr");
  a_mirror_read: assert property (
    rs |=> prdata[14:0] == $past(main_status_register))
    else $error("bad mirror");
  a_xcvr_flag: assert property (
    rs && $stable(transceiver_irq_register) |=>
    prdata[29] == |$past(transceiver_irq_register)) else $error("bad xcvr");
endmodule
bind added_interrupt_status_bank irq_props u_props(.*);

// ===== dv/test_added_interrupt_status_bank.sv
// Bench for the status bank
`timescale 1ns/1ps
module test_added_interrupt_status_bank;
  logic core_clk=0, reset=1, psel=0, penable=0, pwrite=0, pause_enable=1;
  logic pready, pslverr, irq, er, bus_error=0, pause_frame_rx=0;
  logic tx_packet_moved=0, rx_first_desc_filled=0, tx_deferred=0;
  logic [2:0] bus_error_cause=0;
  logic [6:0] transceiver_irq_register=0;
  logic [11:0] paddr=0;
  logic [14:0] main_status_register=0, main_status_clear;
  logic [31:0] pwdata=0, prdata, rd, en;
  int num_errors=0, total_checks=0, i;
  added_interrupt_status_bank dut(.*);
  initial forever #5 core_clk = ~core_clk;
  task chk(input string n, input logic [31:0] s, e);
    total_checks++;
    if (s !== e) begin
      num_errors++;
      $display("[FAIL] %s exp %h seen %h", n, e, s);
    end
  endtask
  task end_sim;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task acc(input logic w, input logic [11:0] a, input logic [31:0] d);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge core_clk) penable <= 1;
    i = 0;
    do @(posedge core_clk); while (pready !== 1 && ++i < 9);
    {rd, er} = {prdata, pslverr};
    {psel, penable} <= 2'b0;
    @(posedge core_clk);
    if (i == 9) begin
      num_errors++;
      end_sim();
    end
  endtask
  // Events are one-cycle pulses, then time for flag and irq to settle
  task ev(input logic [4:0] x);
    repeat (2) begin
      {bus_error, tx_packet_moved, rx_first_desc_filled, tx_deferred,
        pause_frame_rx} <= x;
      x = 0;
      @(posedge core_clk);
    end
    repeat (3) @(posedge core_clk);
  endtask
  initial begin
    void'($urandom(32'hC1C6));
    repeat (5) @(posedge core_clk);
    reset <= 0;
    main_status_register <= 15'($urandom) | 15'h2000;
    en = $urandom | 32'hD4000000;
    @(posedge core_clk);
    acc(1, 12'h084, en);
    acc(0, 12'h084, 0);
    chk("enable", rd, en & 32'hF401FFFF);
    for (int c = 0; c < 3; c++) begin
      bus_error_cause <= 3'(c);
      ev(5'h1F);
      acc(0, 12'h080, 0);
      chk("status", rd & 32'hF7807FFF,
        32'hD4000000 | c << 23 | main_status_register);
      chk("irq", irq, 1);
      acc(1, 12'h080, 32'hD4000000);
      acc(0, 12'h080, 0);
      chk("cleared", rd[31:26], 0);
      chk("irq off", irq, 0);
    end
    transceiver_irq_register <= 7'h40;
    repeat (3) @(posedge core_clk);
    acc(0, 12'h080, 0);
    chk("xcvr", rd[29], 1);
    chk("xcvr irq", irq, en[29]);
    acc(1, 12'h084, 0);
    pause_enable <= 0;
    ev(5'h0F);
    acc(0, 12'h080, 0);
    chk("gated", rd & 32'hD4000000, 32'h10000000);
    chk("masked", irq, 0);
    acc(0, 12'h0FC, 0);
    chk("unmapped", er, 1);
    end_sim();
  end
endmodule
